/* core/tprh_defines.svh */
`ifndef TPRH_DEFINES_SVH
`define TPRH_DEFINES_SVH

// ************************************************************
// subaddress numbers
// ************************************************************
`define TPRH_SA_UNIT      5'h01
`define TPRH_SA_REQ       5'h0a
`define TPRH_SA_FIRST_TM  5'h0b
`define TPRH_SA_LLC       5'h1c

// ************************************************************
// register byte offsets
// ************************************************************
`define TPRH_OFS_CTRL     8'h00
`define TPRH_OFS_SIZE     8'h04
`define TPRH_OFS_STATUS   8'h08
`define TPRH_OFS_REQ0     8'h0c
`define TPRH_OFS_REQ1     8'h10
`define TPRH_OFS_CONF0    8'h14
`define TPRH_OFS_CONF1    8'h18
`define TPRH_OFS_UNIT     8'h1c
`define TPRH_OFS_LLC      8'h20

// ************************************************************
// field positions
// ************************************************************
`define TPRH_CTRL_STAGE   0
`define TPRH_CTRL_EVT_A   1
`define TPRH_CTRL_EVT_B   2
`define TPRH_CTRL_BURST   3
`define TPRH_SIZE_LAST_LO 0
`define TPRH_SIZE_MSGS_LO 8
`define TPRH_STS_STAGED   0
`define TPRH_STS_PEND     1
`define TPRH_STS_CONF     2
`define TPRH_STS_LLC_NEW  3
`define TPRH_STS_UNIT_NEW 4
`define TPRH_STS_CNT_LO   8

// ************************************************************
// flow codes, counter range, reset values, timing
// ************************************************************
`define TPRH_FLOW_NONE    2'h0
`define TPRH_FLOW_PEND    2'h1
`define TPRH_FLOW_FIN     2'h3
`define TPRH_CNT_RESET    8'h00
`define TPRH_CNT_MIN      8'h01
`define TPRH_CNT_MAX      8'hff
`define TPRH_WORD_RESET   16'h0000
`define TPRH_LOAD_WIN_MS  2
`define TPRH_CLK_PERIOD_NS 10
`define TPRH_NS_PER_MS    1000000

`endif

/* core/tprh_pkg.sv */
`include "tprh_defines.svh"

package tprh_pkg;

  // ************************************************************
  // request and confirmation word layouts
  // ************************************************************
  typedef struct packed {
    logic [2:0] rsv_hi;   // always zero
    logic [4:0] msgs;     // messages of the packet
    logic [2:0] rsv_lo;   // always zero
    logic [4:0] last;     // words in last message, 0 means 32
  } tprh_size_t;

  typedef struct packed {
    logic       evt_a;    // event a message pending
    logic       evt_b;    // event b message pending
    logic       burst;    // burst mode
    logic [1:0] flow;     // flow control code
    logic [2:0] rsv;      // always zero
    logic [7:0] count;    // packet count
  } tprh_ctl_t;

  // handshake state, gray along idle, pend, idle
  typedef enum logic {
    TPRH_IDLE = 1'b0,     // no request outstanding
    TPRH_PEND = 1'b1      // request published, waiting on confirm
  } tprh_state_t;

endpackage

/* core/tprh_pkt_cnt.sv */
`timescale 1ns/1ps
`include "tprh_defines.svh"

module tprh_pkt_cnt
  import tprh_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       adv_i,   // one pulse per new request
  output logic      [7:0] cnt_o,   // count of the current request
  output logic      [7:0] nxt_o    // count the next request will carry
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic       first;              // no request since reset
    logic [7:0] cnt;                // running count
  } tprh_cnt_st_t;

  tprh_cnt_st_t st_r;
  tprh_cnt_st_t st_nxt;

  // next count; zero only for the first request, then skipped
  always_comb begin
    if (st_r.first) begin
      nxt_o = `TPRH_CNT_RESET;
    end else if (st_r.cnt == `TPRH_CNT_MAX) begin
      nxt_o = `TPRH_CNT_MIN;
    end else begin
      nxt_o = st_r.cnt + 8'h01;
    end
    st_nxt = st_r;
    if (adv_i) begin
      st_nxt.cnt   = nxt_o;
      st_nxt.first = 1'b0;
    end
  end

  // register the state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{first: 1'b1, cnt: `TPRH_CNT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt_o = st_r.cnt;

endmodule

/* core/tprh_ahb_slv.sv */
`timescale 1ns/1ps

module tprh_ahb_slv
  import tprh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,     // low byte of the address
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o, // from a flop
  output logic             wr_o,        // write data phase
  output logic             rd_o,        // first read data cycle
  output logic       [7:0] addr_o       // address of the data phase
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic       ph_wr;   // write in data phase
    logic       ph_rd;   // read in first data cycle
    logic       rdy;     // hreadyout
    logic [7:0] addr;    // captured address
  } tprh_ahb_st_t;

  tprh_ahb_st_t st_r;
  tprh_ahb_st_t st_nxt;
  logic         take;    // address phase accepted

  // reads take one wait state so the data leaves a flop and any
  // write in the preceding data phase is already visible
  always_comb begin
    take         = hsel_i & htrans_i[1] & hready_i;
    st_nxt       = st_r;
    st_nxt.ph_wr = take & hwrite_i;
    st_nxt.ph_rd = take & ~hwrite_i;
    if (take) begin
      st_nxt.addr = haddr_i;
    end
    if (take & ~hwrite_i) begin
      st_nxt.rdy = 1'b0;    // hold the read one cycle
    end else if (st_r.ph_rd) begin
      st_nxt.rdy = 1'b1;    // read data now registered
    end
  end

  // register the state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{ph_wr: 1'b0, ph_rd: 1'b0, rdy: 1'b1, addr: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout_o = st_r.rdy;
  assign wr_o        = st_r.ph_wr;
  assign rd_o        = st_r.ph_rd;
  assign addr_o      = st_r.addr;

endmodule

/* core/tprh_top.sv */
// How it works
// - accept low-level commands on receive subaddress 28
// - read back low-level commands on transmit 28
// - accept unit-control commands on receive subaddress 1
// - publish two request words on transmit 10
// - first word: zeros, message count, zeros, words
// - all reserved request bits read zero
// - message count sized from next packet, start at 8
// - last message words, 32 coded as zero
// - second word carries event a and b flags
// - flow codes 00, 01, 11; device never emits 11
// - eight-bit circular count bumps per new request
// - nominal counts stay within 1 to 255
// - first request after reset carries count zero
// - wrap 255 to 1, zero never reused
// - counter serves request identification only
// - completion found by matching the returned count
// - check at sync, reload within 2 ms window
// - nothing new: size zero, count kept, flow 00
// - burst bit one for burst, zero nominal
`timescale 1ns/1ps
`include "tprh_defines.svh"

module tprh_top
  import tprh_pkg::*;
#(
  parameter int LLC_WORDS    = 4,     // stored low-level command words
  parameter int LOAD_WIN_CYC = (`TPRH_LOAD_WIN_MS * `TPRH_NS_PER_MS)
                               / `TPRH_CLK_PERIOD_NS
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [31:0] hrdata_o,
  // subaddress access from the remote terminal protocol core
  input  wire logic        sa_strobe_i,  // one word moved on the bus
  input  wire logic        sa_tx_i,      // 1 = controller reads
  input  wire logic [4:0]  sa_num_i,     // subaddress
  input  wire logic [4:0]  sa_idx_i,     // word index in message
  input  wire logic [15:0] sa_wdata_i,   // word from controller
  output logic      [15:0] sa_rdata_o,   // word to controller
  output logic             sa_rvalid_o,  // sa_rdata_o valid pulse
  // subframe synchronize mode command
  input  wire logic        sync_i
);

  // ************************************************************
  // sizes and state
  // ************************************************************
  // one spare state keeps the count from wrapping
  localparam int WIN_W = $clog2(LOAD_WIN_CYC + 1);
  localparam int IDX_W = (LLC_WORDS > 1) ? $clog2(LLC_WORDS) : 1;
  localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(LOAD_WIN_CYC - 1);

  typedef struct packed {
    logic                        ctl_evt_a;  // software event a
    logic                        ctl_evt_b;  // software event b
    logic                        ctl_burst;  // software burst mode
    logic [4:0]                  size_msgs;  // staged message count
    logic [4:0]                  size_last;  // staged last words
    logic                        staged;     // new packet waiting
    tprh_state_t                 hs;         // handshake state
    tprh_size_t                  req0;       // published word 0
    tprh_ctl_t                   req1;       // published word 1
    logic [15:0]                 shadow1;    // word 1 frozen at read
    logic [15:0]                 conf0;      // confirm word 0
    tprh_ctl_t                   conf1;      // confirm word 1
    logic                        conf_ok;    // sticky: confirmed
    logic                        llc_new;    // sticky: llc written
    logic                        unit_new;   // sticky: unit written
    logic [15:0]                 unit_cmd;   // last unit command
    logic [LLC_WORDS-1:0][15:0]  llc;        // low-level commands
    logic [WIN_W-1:0]            win_cnt;    // load window countdown
    logic                        win_open;   // inside load window
    logic                        synced;     // any sync seen
    logic [15:0]                 sa_rdata;   // word to controller
    logic                        sa_rvalid;  // word valid
    logic [31:0]                 hrdata;     // bus read data
    logic                        hresp;      // always okay
  } tprh_top_st_t;

  tprh_top_st_t st_r;
  tprh_top_st_t st_nxt;

  logic             bus_wr;     // write data phase
  logic             bus_rd;     // read to register
  logic [7:0]       bus_addr;   // data phase address
  logic             cnt_adv;    // new request loaded
  logic [7:0]       cnt_cur;    // current packet count
  logic [7:0]       cnt_nxt;    // count for the next request
  logic             confirm;    // confirmation matched at sync
  logic             may_load;   // request slot free and in time
  logic [31:0]      rd_word;    // read mux
  logic [IDX_W-1:0] sa_sel;     // llc word selected by index

  // ************************************************************
  // bus slave and packet counter
  // ************************************************************
  // low address byte only; hsize is unused
  // as every access is one word
  tprh_ahb_slv u_ahb (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i[7:0]),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .wr_o        (bus_wr),
    .rd_o        (bus_rd),
    .addr_o      (bus_addr)
  );

  // counter feeds the request words, the match and the status register
  tprh_pkt_cnt u_cnt (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .adv_i   (cnt_adv),
    .cnt_o   (cnt_cur),
    .nxt_o   (cnt_nxt)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_adv = 1'b0;
    sa_sel  = sa_idx_i[IDX_W-1:0];
    rd_word = 32'h0000_0000;

    // register read mux; unmapped offsets read zero
    case (bus_addr)
      `TPRH_OFS_CTRL: begin
        rd_word[`TPRH_CTRL_EVT_A] = st_r.ctl_evt_a;
        rd_word[`TPRH_CTRL_EVT_B] = st_r.ctl_evt_b;
        rd_word[`TPRH_CTRL_BURST] = st_r.ctl_burst;
      end
      `TPRH_OFS_SIZE: begin
        rd_word[`TPRH_SIZE_MSGS_LO +: 5] = st_r.size_msgs;
        rd_word[`TPRH_SIZE_LAST_LO +: 5] = st_r.size_last;
      end
      `TPRH_OFS_STATUS: begin
        rd_word[`TPRH_STS_STAGED]     = st_r.staged;
        rd_word[`TPRH_STS_PEND]       = (st_r.hs == TPRH_PEND);
        rd_word[`TPRH_STS_CONF]       = st_r.conf_ok;
        rd_word[`TPRH_STS_LLC_NEW]    = st_r.llc_new;
        rd_word[`TPRH_STS_UNIT_NEW]   = st_r.unit_new;
        rd_word[`TPRH_STS_CNT_LO +: 8] = cnt_cur;
      end
      `TPRH_OFS_REQ0:  rd_word[15:0] = st_r.req0;
      `TPRH_OFS_REQ1:  rd_word[15:0] = st_r.req1;
      `TPRH_OFS_CONF0: rd_word[15:0] = st_r.conf0;
      `TPRH_OFS_CONF1: rd_word[15:0] = st_r.conf1;
      `TPRH_OFS_UNIT:  rd_word[15:0] = st_r.unit_cmd;
      default: begin
        // llc words sit in consecutive words from their base
        for (int i = 0; i < LLC_WORDS; i++) begin
          if (bus_addr == 8'(`TPRH_OFS_LLC + 4 * i)) begin
            rd_word[15:0] = st_r.llc[i];
          end
        end
      end
    endcase
    if (bus_rd) begin
      st_nxt.hrdata = rd_word;
    end

    // software writes; sticky status bits clear on writing one
    if (bus_wr) begin
      case (bus_addr)
        `TPRH_OFS_CTRL: begin
          st_nxt.ctl_evt_a = hwdata_i[`TPRH_CTRL_EVT_A];
          st_nxt.ctl_evt_b = hwdata_i[`TPRH_CTRL_EVT_B];
          st_nxt.ctl_burst = hwdata_i[`TPRH_CTRL_BURST];
          // stage is a strobe, never stored as is
          if (hwdata_i[`TPRH_CTRL_STAGE]) begin
            st_nxt.staged = 1'b1;
          end
        end
        `TPRH_OFS_SIZE: begin
          st_nxt.size_msgs = hwdata_i[`TPRH_SIZE_MSGS_LO +: 5];
          st_nxt.size_last = hwdata_i[`TPRH_SIZE_LAST_LO +: 5];
        end
        `TPRH_OFS_STATUS: begin
          if (hwdata_i[`TPRH_STS_CONF]) begin
            st_nxt.conf_ok = 1'b0;
          end
          if (hwdata_i[`TPRH_STS_LLC_NEW]) begin
            st_nxt.llc_new = 1'b0;
          end
          if (hwdata_i[`TPRH_STS_UNIT_NEW]) begin
            st_nxt.unit_new = 1'b0;
          end
        end
        default: ;  // read-only or unmapped, write ignored
      endcase
    end

    // event and burst flags follow software at once
    st_nxt.req1.evt_a = st_nxt.ctl_evt_a;
    st_nxt.req1.evt_b = st_nxt.ctl_evt_b;
    st_nxt.req1.burst = st_nxt.ctl_burst;
    st_nxt.req1.rsv   = 3'h0;

    // reading word 0 freezes word 1 so a
    // flag change cannot tear the pair
    // subaddress traffic; sets come after software clears
    st_nxt.sa_rvalid = 1'b0;
    if (sa_strobe_i && sa_tx_i) begin
      st_nxt.sa_rvalid = 1'b1;
      st_nxt.sa_rdata  = `TPRH_WORD_RESET;
      case (sa_num_i)
        `TPRH_SA_REQ: begin
          if (sa_idx_i == 5'h00) begin
            st_nxt.sa_rdata = st_r.req0;
            st_nxt.shadow1  = st_r.req1;
          end else if (sa_idx_i == 5'h01) begin
            st_nxt.sa_rdata = st_r.shadow1;
          end
        end
        `TPRH_SA_LLC: begin
          if (32'(sa_idx_i) < LLC_WORDS) begin
            st_nxt.sa_rdata = st_r.llc[sa_sel];
          end
        end
        default: ;  // other transmit subaddresses served elsewhere
      endcase
    end else if (sa_strobe_i) begin
      case (sa_num_i)
        `TPRH_SA_REQ: begin
          if (sa_idx_i == 5'h00) begin
            st_nxt.conf0 = sa_wdata_i;
          end else if (sa_idx_i == 5'h01) begin
            st_nxt.conf1 = sa_wdata_i;
          end
        end
        `TPRH_SA_LLC: begin
          if (32'(sa_idx_i) < LLC_WORDS) begin
            st_nxt.llc[sa_sel] = sa_wdata_i;
            st_nxt.llc_new     = 1'b1;
          end
        end
        `TPRH_SA_UNIT: begin
          st_nxt.unit_cmd = sa_wdata_i;
          st_nxt.unit_new = 1'b1;
        end
        default: ;  // other receive subaddresses served elsewhere
      endcase
    end

    // load window opens at every subframe sync
    // a sync in an open window restarts it
    if (sync_i) begin
      st_nxt.win_cnt  = WIN_LOAD;
      st_nxt.win_open = 1'b1;
      st_nxt.synced   = 1'b1;
    end else if (st_r.win_open) begin
      if (st_r.win_cnt == '0) begin
        st_nxt.win_open = 1'b0;
      end else begin
        st_nxt.win_cnt = st_r.win_cnt - 1'b1;
      end
    end

    // a stale confirm word never matches:
    // the count has moved on since then
    // confirmation is judged only at sync; the count match keeps
    // equal-sized packets apart
    confirm = sync_i && (st_r.hs == TPRH_PEND)
              && (st_r.conf1.flow == `TPRH_FLOW_FIN)
              && (st_r.conf1.count == cnt_cur);
    if (confirm) begin
      st_nxt.conf_ok    = 1'b1;
      st_nxt.req0       = `TPRH_WORD_RESET;
      st_nxt.req1.flow  = `TPRH_FLOW_NONE;
      st_nxt.hs         = TPRH_IDLE;
    end

    // a staged packet is published only while the slot is free and
    // either before the first sync or inside the load window; a late
    // stage waits for the next subframe
    may_load = ((st_r.hs == TPRH_IDLE) || confirm) && st_nxt.staged
               && (sync_i || st_r.win_open || !st_r.synced);
    // words and counter move in one cycle,
    // so size and count always belong together
    if (may_load) begin
      st_nxt.req0.rsv_hi = 3'h0;
      st_nxt.req0.msgs   = st_nxt.size_msgs;
      st_nxt.req0.rsv_lo = 3'h0;
      st_nxt.req0.last   = st_nxt.size_last;
      st_nxt.req1.flow   = `TPRH_FLOW_PEND;
      st_nxt.req1.count  = cnt_nxt;
      st_nxt.staged      = 1'b0;
      st_nxt.hs          = TPRH_PEND;
      cnt_adv            = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset clears all: flow none, idle,
  // no events, window shut
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;    // flow none, count zero, idle, all clear
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the slave never reports an error
  assign hresp_o     = st_r.hresp;
  assign hrdata_o    = st_r.hrdata;
  // word stands until the next read strobe
  assign sa_rdata_o  = st_r.sa_rdata;
  assign sa_rvalid_o = st_r.sa_rvalid;

endmodule

/* sim/tprh_sva.sv */
`timescale 1ns/1ps
`include "tprh_defines.svh"

// ************************************************************
// port checker of the request handshake
// ************************************************************
module tprh_sva #(
  parameter int LLC_WORDS = 4  // stored command words
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        sa_strobe_i,
  input wire logic        sa_tx_i,
  input wire logic [4:0]  sa_num_i,
  input wire logic [4:0]  sa_idx_i,
  input wire logic [15:0] sa_wdata_i,
  input wire logic [15:0] sa_rdata_o,
  input wire logic        sa_rvalid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // reply to a read of request word i
  sequence s_req(int i);
    sa_rvalid_o && $past(sa_num_i) == `TPRH_SA_REQ && $past(sa_idx_i) == i;
  endsequence
  property p_rv;
    sa_strobe_i && sa_tx_i |=> sa_rvalid_o;
  endproperty
  a_rv: assert property (p_rv)
    else $error("read strobe got no reply");
  property p_rv_only;
    !(sa_strobe_i && sa_tx_i) |=> !sa_rvalid_o;
  endproperty
  a_rv_only: assert property (p_rv_only)
    else $error("reply without a read strobe");
  property p_w0_rsv;
    s_req(0) |-> sa_rdata_o[15:13] == 3'h0 && sa_rdata_o[7:5] == 3'h0;
  endproperty
  a_w0_rsv: assert property (p_w0_rsv)
    else $error("size word spare bits set");
  property p_w1_rsv;
    s_req(1) |-> sa_rdata_o[10:8] == 3'h0;
  endproperty
  a_w1_rsv: assert property (p_w1_rsv)
    else $error("control word spare bits set");
  // codes 10 and 11 never come from this side
  property p_flow;
    s_req(1) |-> !sa_rdata_o[12];
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow code not allowed here");
  property p_other;
    sa_rvalid_o && !($past(sa_num_i) inside {`TPRH_SA_REQ, `TPRH_SA_LLC})
      |-> sa_rdata_o == 16'h0;
  endproperty
  a_other: assert property (p_other)
    else $error("unused subaddress gave data");
  // command stored, then read back unchanged
  property p_llc;
    sa_strobe_i && !sa_tx_i && sa_num_i == `TPRH_SA_LLC
      && sa_idx_i < LLC_WORDS ##1 !sa_strobe_i [*2] ##1 sa_strobe_i
      && sa_tx_i && sa_num_i == `TPRH_SA_LLC && sa_idx_i == $past(sa_idx_i, 3)
      |=> sa_rdata_o == $past(sa_wdata_i, 4);
  endproperty
  a_llc: assert property (p_llc)
    else $error("command read back differs");
  property p_rd_wait;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i
      |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("register read wait wrong");
  c_poll: cover property (s_req(1));
  c_llc: cover property (sa_strobe_i && !sa_tx_i && sa_num_i == 5'h1c);
  c_rd: cover property (hsel_i && htrans_i[1] && hready_i && !hwrite_i);
endmodule

bind tprh_top tprh_sva #(.LLC_WORDS(LLC_WORDS)) sva_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .sa_strobe_i(sa_strobe_i), .sa_tx_i(sa_tx_i), .sa_num_i(sa_num_i),
  .sa_idx_i(sa_idx_i), .sa_wdata_i(sa_wdata_i), .sa_rdata_o(sa_rdata_o),
  .sa_rvalid_o(sa_rvalid_o));

/* sim/tprh_bc_model.sv */
`timescale 1ns/1ps
`include "tprh_defines.svh"

// ************************************************************
// bus controller model
// ************************************************************
module tprh_bc_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic             strobe_o,
  output logic             tx_o,
  output logic [4:0]       num_o,
  output logic [4:0]       idx_o,
  output logic [15:0]      wdata_o,
  output logic             sync_o
);
  logic [15:0] w0, w1;    // request pair of the last poll
  logic [7:0]  last_cnt;  // count of the last accepted request
  logic        is_new;    // last poll held a new request
  logic [15:0] q;         // discarded reply
  initial begin
    {strobe_o, tx_o, num_o, idx_o, sync_o} = '0;
    wdata_o  = 16'hffff;
    last_cnt = 8'hff;  // differs from the first count after reset
  end
  // one word moved; data line toggles once released
  task xfer(input logic t, input logic [4:0] n, input logic [4:0] i,
            input logic [15:0] d, output logic [15:0] r);
    @(posedge clk_i);
    strobe_o <= 1'b1;
    tx_o     <= t;
    num_o    <= n;
    idx_o    <= i;
    wdata_o  <= d;
    @(posedge clk_i);
    strobe_o <= 1'b0;
    wdata_o  <= ~d;
    @(posedge clk_i);
    r = rdata_i;
  endtask
  // word 0 first, so the pair is consistent
  task poll();
    xfer(1'b1, `TPRH_SA_REQ, 5'h0, 16'h0, w0);
    xfer(1'b1, `TPRH_SA_REQ, 5'h1, 16'h0, w1);
    is_new = (w1[7:0] != last_cnt);
    if (is_new) last_cnt = w1[7:0];
  endtask
  // sent before the sync that closes the subframe
  task confirm(input logic [7:0] c);
    xfer(1'b0, `TPRH_SA_REQ, 5'h0, w0, q);
    xfer(1'b0, `TPRH_SA_REQ, 5'h1,
         {2'b00, w1[13], 2'b11, 3'b000, c}, q);
  endtask
  task sync();
    @(posedge clk_i);
    sync_o <= 1'b1;
    @(posedge clk_i);
    sync_o <= 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "tprh_defines.svh"

// ************************************************************
// self-checking bench
// ************************************************************
module testbench;
  localparam int WIN = 20;  // short load window keeps the run brief
  logic        clk_i, rst_b_i, hwrite_i, hready, st, tx, sync, rv, hresp;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata, q;
  logic [4:0]  num, idx;
  logic [15:0] wd, rd, r;
  logic [7:0]  exp;
  int          fail_count, comparisons;

  tprh_top #(.LLC_WORDS(4), .LOAD_WIN_CYC(WIN)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .sa_strobe_i(st), .sa_tx_i(tx),
    .sa_num_i(num), .sa_idx_i(idx), .sa_wdata_i(wd), .sa_rdata_o(rd),
    .sa_rvalid_o(rv), .sync_i(sync));
  tprh_bc_model bc_u (.clk_i(clk_i), .rdata_i(rd), .strobe_o(st),
    .tx_o(tx), .num_o(num), .idx_o(idx), .wdata_o(wd), .sync_o(sync));

  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // one single transfer; address held until ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  task stop_test();
    $display("compared %0d, bad %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog: about four times the expected run
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    {rst_b_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // first request: 3 messages, last one full, events a and b, burst
    ahb(1, `TPRH_OFS_SIZE, 32'h0300);
    ahb(1, `TPRH_OFS_CTRL, 32'h000f);
    repeat (3) @(posedge clk_i);
    ahb(0, `TPRH_OFS_REQ0, 0);
    chk(q, 32'h0300);
    bc_u.poll();
    chk(bc_u.w1, 16'he800);
    ahb(1, `TPRH_OFS_CTRL, 0);
    bc_u.confirm(bc_u.w1[7:0]);
    bc_u.sync();
    bc_u.poll();
    chk({bc_u.w0, bc_u.w1}, 32'h0);
    ahb(0, `TPRH_OFS_STATUS, 0);
    chk(q, 32'h0004);
    $display("test first request done");
    // staged after the window: waits for the next sync
    repeat (WIN + 5) @(posedge clk_i);
    ahb(1, `TPRH_OFS_SIZE, 32'h0105);
    ahb(1, `TPRH_OFS_CTRL, 32'h0001);
    repeat (3) @(posedge clk_i);
    bc_u.poll();
    chk(bc_u.w1, 16'h0);
    bc_u.sync();
    bc_u.poll();
    chk({bc_u.w0, bc_u.w1}, 32'h0105_0801);
    bc_u.confirm(8'h02);
    bc_u.sync();
    bc_u.poll();
    chk(bc_u.w1, 16'h0801);
    bc_u.xfer(0, `TPRH_SA_REQ, 5'h1, 16'h0801, r);
    bc_u.sync();
    bc_u.poll();
    chk(bc_u.w1, 16'h0801);
    $display("test load window done");
    // walk the count through its wrap
    exp = 8'h01;
    for (int i = 0; i < 256; i++) begin
      ahb(1, `TPRH_OFS_CTRL, 32'h0001);
      bc_u.confirm(bc_u.w1[7:0]);
      bc_u.sync();
      bc_u.poll();
      exp = (exp == 8'hff) ? 8'h01 : exp + 8'h01;
      chk(bc_u.w1, {8'h08, exp});
    end
    $display("test count wrap done");
    // stored commands read back on both sides
    for (int i = 0; i < 4; i++) begin
      bc_u.xfer(0, `TPRH_SA_LLC, 5'(i), 16'h5a00 + 16'(i), r);
      bc_u.xfer(1, `TPRH_SA_LLC, 5'(i), 16'h0, r);
      chk(r, 16'h5a00 + 16'(i));
      ahb(0, 8'h20 + 8'(4 * i), 0);
      chk(q, 32'h5a00 + i);
    end
    bc_u.xfer(0, `TPRH_SA_UNIT, 5'h3, 16'h1234, r);
    ahb(0, `TPRH_OFS_UNIT, 0);
    chk(q, 32'h1234);
    ahb(0, `TPRH_OFS_STATUS, 0);
    chk(q[4:3], 2'h3);
    bc_u.xfer(1, 5'h05, 5'h0, 16'h0, r);
    chk(r, 16'h0);
    ahb(0, 8'hfc, 0);
    chk(q, 32'h0);
    $display("test commands done");
    stop_test();
  end
endmodule
